// ### logic/scb_pkg.sv
// Summary of operation
// - With internal clock, wait code 00/01/10/11 stretches frame to 1/2/4/8 transfer times.
// - Count code 000..111 selects 1..8 words, entries used upward from first.
// - Nibble mode shifts low nibble only; received upper nibble stored zero.
// - Send from lowest entry first; store received words lowest upward.
// - Programmed word count stays unchanged after a batch completes.
// - Wait/count register is write-only; reads do not return it.
// - Transfer-active flag reads one while transfer runs, zero after.
// - Shift-active flag reads one while shifting, zero otherwise.
// - With go cleared, active flag drops at end; abort also clears it.
// - Clock select picks divider rate, low-frequency rate or external.
// - Internal clock drives the clock pin, high when transfer starts.
// - Internal clock halts until software services the buffer in time.
// - Transmit bit changes on falling clock pin edge.
// - Receive bit sampled on rising clock pin edge.
// - Every word goes least significant bit first.
// - Batch interrupt fires when the programmed word count is done.
// - Count change mid-transfer needs stop, except during automatic wait.
// - Mode codes: 000 tx8, 010 tx4, 100 txrx8, 101 rx8, 110 rx4.
// - Abort ends transfer at once, clears active, then clears itself.
// - Go cleared during transmit finishes current word before ending.
package scb_pkg;
   // Register indices; byte address is four times the index
   localparam logic [11:0] IDX_BUF_BASE = 12'hF90;
   localparam logic [11:0] IDX_CTRL_MAIN = 12'hF98;
   localparam logic [11:0] IDX_WAIT_COUNT = 12'hF99;
   localparam logic [11:0] IDX_STATUS = 12'hF99;
   localparam logic [11:0] IDX_CONFIG = 12'hF9A;
   // Field positions
   localparam int CM_GO_BIT = 7;
   localparam int CM_ABORT_BIT = 6;
   localparam int CM_MODE_LSB = 3;
   localparam int CM_CLK_LSB = 0;
   localparam int WC_WAIT_LSB = 3;
   localparam int WC_COUNT_LSB = 0;
   localparam int ST_ACTIVE_BIT = 7;
   localparam int ST_SHIFT_BIT = 6;
   localparam int CF_DIVSEL_BIT = 0;
   localparam int CF_SLOW_BIT = 1;
   // Reset values
   localparam logic [2:0] RST_MODE = 3'h0;
   localparam logic [2:0] RST_CLKSEL = 3'h0;
   localparam logic [1:0] RST_WAIT = 2'h0;
   localparam logic [2:0] RST_COUNT = 3'h0;
   // Mode and clock codes
   localparam logic [2:0] MODE_TX8 = 3'h0;
   localparam logic [2:0] MODE_TX4 = 3'h2;
   localparam logic [2:0] MODE_TXRX8 = 3'h4;
   localparam logic [2:0] MODE_RX8 = 3'h5;
   localparam logic [2:0] MODE_RX4 = 3'h6;
   localparam logic [2:0] CLK_RSV = 3'h6;
   localparam logic [2:0] CLK_EXT = 3'h7;
   // Divider exponents: serial rate is source clock over two to these
   localparam int DIV_EXP_SEL0 = 13;
   localparam int DIV_EXP_SEL1 = 8;
   localparam int DIV_EXP_SEL2 = 7;
   localparam int DIV_EXP_SEL3 = 6;
   localparam int DIV_EXP_SEL4 = 5;
   localparam int DIV_EXP_SEL5 = 4;
   localparam int LF_DIV_EXP = 5;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_SHIFT = 2'b01,
      ST_GAP = 2'b10,
      ST_HOLD = 2'b11
   } scb_phase_e;

   function automatic logic scb_mode_tx(input logic [2:0] m);
      return (m == MODE_TX8) || (m == MODE_TX4) || (m == MODE_TXRX8);
   endfunction

   function automatic logic scb_mode_rx(input logic [2:0] m);
      return (m == MODE_TXRX8) || (m == MODE_RX8) || (m == MODE_RX4);
   endfunction

   function automatic logic scb_mode_nib(input logic [2:0] m);
      return (m == MODE_TX4) || (m == MODE_RX4);
   endfunction

   function automatic logic scb_mode_ok(input logic [2:0] m);
      return scb_mode_tx(m) || scb_mode_rx(m);
   endfunction
endpackage

// ### logic/scb_serial_port.sv
// Register access over AHB-Lite was decided locally.
`timescale 1ns/1ns
module scb_serial_port (
   // Clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // Serial pins
   input wire logic sck_i,
   output logic sck_o,
   output logic sck_oe,
   output logic so,
   input wire logic si,
   // Low-frequency clock input, sampled as a pin
   input wire logic lf_clk,
   // Batch event
   output logic batch_interrupt
);
   import scb_pkg::*;

   typedef struct packed {
      scb_phase_e ph;
      logic go;
      logic [2:0] mode;
      logic [2:0] clksel;
      logic [1:0] wait_sel;
      logic [2:0] count;
      logic div_sel;
      logic slow;
      logic active;
      logic [7:0][7:0] buff;
      logic [7:0] shreg;
      logic [2:0] bitcnt;
      logic [2:0] word;
      logic [12:0] divcnt;
      logic [7:0] gapcnt;
      logic sck;
      logic sck_oe;
      logic so;
      logic serviced;
      logic si1, si2, sc1, sc2, sc3, lf1, lf2, lf3;
      logic wr_pend;
      logic [11:0] wr_idx;
      logic irq;
      logic [31:0] rdata;
      logic rdy;
   } scb_state_s;

   scb_state_s st_r;
   scb_state_s st_nxt;

   logic aphase_c, inmap_c, svc_c, internal_c, use_lf_c, nib_c, tick_c;
   logic expire_c, fall_c, rise_c, done_c, last_c, launch_c;
   logic [11:0] aidx_c;
   logic [7:0] d_c, rdval_c, shifted_c;
   logic [12:0] reload_c;
   logic [2:0] nword_c;

   // Half period of the serial clock in source ticks
   function automatic logic [12:0] scb_half(input logic [2:0] sel,
                                            input logic lf);
      logic [12:0] one;
      one = 13'h0001;
      if (lf) return one << (LF_DIV_EXP - 1);
      unique case (sel)
         3'h0: return one << (DIV_EXP_SEL0 - 1);
         3'h1: return one << (DIV_EXP_SEL1 - 1);
         3'h2: return one << (DIV_EXP_SEL2 - 1);
         3'h3: return one << (DIV_EXP_SEL3 - 1);
         3'h4: return one << (DIV_EXP_SEL4 - 1);
         default: return one << (DIV_EXP_SEL5 - 1);
      endcase
   endfunction

   // Idle half periods between words: (2^w - 1) frames of word bits
   function automatic logic [7:0] scb_gap(input logic [1:0] w,
                                          input logic nib);
      logic [7:0] frames;
      frames = (8'h01 << w) - 8'h01;
      return 8'(frames * (nib ? 8'h08 : 8'h10));
   endfunction

   // Next-state logic: bus slave, pin sampling and serial engine
   always_comb begin
      st_nxt = st_r;
      svc_c = 1'b0;
      done_c = 1'b0;
      last_c = 1'b0;
      launch_c = 1'b0;
      expire_c = 1'b0;
      fall_c = 1'b0;
      rise_c = 1'b0;
      nword_c = 3'h0;
      rdval_c = 8'h00;
      d_c = hwdata[7:0];
      st_nxt.irq = 1'b0;
      st_nxt.rdy = 1'b1;

      // Two-stage synchronisers; edges only from the second stage on
      st_nxt.si1 = si;
      st_nxt.si2 = st_r.si1;
      st_nxt.sc1 = sck_i;
      st_nxt.sc2 = st_r.sc1;
      st_nxt.sc3 = st_r.sc2;
      st_nxt.lf1 = lf_clk;
      st_nxt.lf2 = st_r.lf1;
      st_nxt.lf3 = st_r.lf2;

      internal_c = (st_r.clksel != CLK_EXT);
      use_lf_c = (st_r.clksel == 3'h0) && (st_r.div_sel || st_r.slow);
      nib_c = scb_mode_nib(st_r.mode);
      reload_c = scb_half(st_r.clksel, use_lf_c);
      tick_c = use_lf_c ? (st_r.lf2 && !st_r.lf3) : 1'b1;

      // Address phase: decode and register read data
      aphase_c = hsel && htrans[1] && hready;
      aidx_c = haddr[13:2];
      inmap_c = (haddr[31:14] == 18'h0) && (haddr[1:0] == 2'h0)
                && (hsize == 3'h2);
      st_nxt.wr_pend = aphase_c && hwrite && inmap_c;
      st_nxt.wr_idx = aidx_c;
      if (aphase_c && !hwrite && inmap_c) begin
         if (aidx_c[11:3] == IDX_BUF_BASE[11:3]) begin
            rdval_c = st_r.buff[aidx_c[2:0]];
            // A read frees a held receive-only batch
            svc_c = scb_mode_rx(st_r.mode) && !scb_mode_tx(st_r.mode);
         end else if (aidx_c == IDX_STATUS) begin
            rdval_c[ST_ACTIVE_BIT] = st_r.active;
            rdval_c[ST_SHIFT_BIT] = (st_r.ph == ST_SHIFT);
         end else if (aidx_c == IDX_CONFIG) begin
            rdval_c[CF_DIVSEL_BIT] = st_r.div_sel;
            rdval_c[CF_SLOW_BIT] = st_r.slow;
         end
         // Main control is write-only and reads as zero; the wait/count index reads status
      end
      if (aphase_c && !hwrite) begin
         st_nxt.rdata = {24'h0, rdval_c};
      end

      // Data phase of a write
      if (st_r.wr_pend) begin
         if (st_r.wr_idx[11:3] == IDX_BUF_BASE[11:3]) begin
            st_nxt.buff[st_r.wr_idx[2:0]] = d_c;
            svc_c = svc_c || scb_mode_tx(st_r.mode);
         end else if (st_r.wr_idx == IDX_WAIT_COUNT) begin
            // Taken at any time; stopping first is up to software
            st_nxt.wait_sel = d_c[WC_WAIT_LSB +: 2];
            st_nxt.count = d_c[WC_COUNT_LSB +: 3];
         end else if (st_r.wr_idx == IDX_CONFIG) begin
            st_nxt.div_sel = d_c[CF_DIVSEL_BIT];
            st_nxt.slow = d_c[CF_SLOW_BIT];
         end else if (st_r.wr_idx == IDX_CTRL_MAIN) begin
            st_nxt.go = d_c[CM_GO_BIT];
            st_nxt.mode = d_c[CM_MODE_LSB +: 3];
            st_nxt.clksel = d_c[CM_CLK_LSB +: 3];
            // Start only from idle with a legal mode and clock
            if (d_c[CM_GO_BIT] && !d_c[CM_ABORT_BIT]
                && st_r.ph == ST_IDLE
                && scb_mode_ok(d_c[CM_MODE_LSB +: 3])
                && d_c[CM_CLK_LSB +: 3] != CLK_RSV) begin
               st_nxt.ph = ST_SHIFT;
               st_nxt.active = 1'b1;
               st_nxt.sck = 1'b1;
               st_nxt.word = 3'h0;
               st_nxt.bitcnt = 3'h0;
               st_nxt.serviced = 1'b0;
               st_nxt.shreg = st_r.buff[0];
               st_nxt.divcnt = scb_half(d_c[CM_CLK_LSB +: 3],
                  (d_c[CM_CLK_LSB +: 3] == 3'h0)
                  && (st_r.div_sel || st_r.slow));
            end
         end
      end

      // Serial clock edges, internal divider or synchronised pin
      if (st_r.ph == ST_SHIFT || st_r.ph == ST_GAP) begin
         if (internal_c && tick_c) begin
            if (st_r.divcnt <= 13'h0001) begin
               expire_c = 1'b1;
               st_nxt.divcnt = reload_c;
            end else begin
               st_nxt.divcnt = st_r.divcnt - 13'h0001;
            end
         end
      end
      if (st_r.ph == ST_SHIFT) begin
         if (internal_c) begin
            fall_c = expire_c && st_r.sck;
            rise_c = expire_c && !st_r.sck;
            if (expire_c) st_nxt.sck = !st_r.sck;
         end else begin
            fall_c = st_r.sc3 && !st_r.sc2;
            rise_c = !st_r.sc3 && st_r.sc2;
         end
      end

      // Shift right, new bit enters at the top of the used width
      shifted_c = nib_c ? {st_r.shreg[7:4], st_r.si2, st_r.shreg[3:1]}
                        : {st_r.si2, st_r.shreg[7:1]};

      unique case (st_r.ph)
         ST_IDLE: begin
            st_nxt.sck = 1'b1;
         end
         ST_SHIFT: begin
            if (fall_c) st_nxt.so = st_r.shreg[0];
            if (rise_c) begin
               st_nxt.shreg = shifted_c;
               st_nxt.bitcnt = st_r.bitcnt + 3'h1;
               if (st_r.bitcnt == (nib_c ? 3'h3 : 3'h7)) begin
                  done_c = 1'b1;
                  st_nxt.bitcnt = 3'h0;
               end
            end
         end
         ST_GAP: begin
            st_nxt.sck = 1'b1;
            // A cleared go ends the batch here; no new word is begun
            if (!st_r.go) begin
               st_nxt.ph = ST_IDLE;
               st_nxt.active = 1'b0;
            end else if (expire_c) begin
               if (st_r.gapcnt <= 8'h01) launch_c = 1'b1;
               else st_nxt.gapcnt = st_r.gapcnt - 8'h01;
            end
         end
         ST_HOLD: begin
            st_nxt.sck = 1'b1;
            if (!st_r.go) begin
               st_nxt.ph = ST_IDLE;
               st_nxt.active = 1'b0;
            end else if (st_r.serviced || svc_c) begin
               launch_c = 1'b1;
            end
         end
      endcase

      // End of a word: store, advance, decide how to go on
      if (done_c) begin
         if (scb_mode_rx(st_r.mode)) begin
            st_nxt.buff[st_r.word] = nib_c ? {4'h0, shifted_c[3:0]}
                                           : shifted_c;
         end
         last_c = (st_r.word == st_r.count);
         nword_c = last_c ? 3'h0 : st_r.word + 3'h1;
         st_nxt.word = nword_c;
         if (last_c) begin
            st_nxt.irq = 1'b1;
            // Count is left as written for the next batch
            // A service access in this very cycle still counts
            st_nxt.serviced = svc_c;
         end else if (svc_c) begin
            st_nxt.serviced = 1'b1;
         end
         if (!st_r.go) begin
            st_nxt.ph = ST_IDLE;
            st_nxt.active = 1'b0;
         end else if (internal_c && last_c && !svc_c) begin
            st_nxt.ph = ST_HOLD;
         end else if (internal_c && st_r.wait_sel != 2'h0) begin
            st_nxt.ph = ST_GAP;
            st_nxt.gapcnt = scb_gap(st_r.wait_sel, nib_c);
            st_nxt.divcnt = reload_c;
         end else begin
            launch_c = 1'b1;
         end
      end else if (svc_c) begin
         st_nxt.serviced = 1'b1;
      end

      // Begin the next word from the buffer
      if (launch_c) begin
         st_nxt.ph = ST_SHIFT;
         st_nxt.sck = 1'b1;
         st_nxt.shreg = st_nxt.buff[st_nxt.word];
         st_nxt.divcnt = reload_c;
      end

      // Abort wins over phase, active flag, clock, bit and word counts; never stays set
      if (st_r.wr_pend && st_r.wr_idx == IDX_CTRL_MAIN
          && d_c[CM_ABORT_BIT]) begin
         st_nxt.ph = ST_IDLE;
         st_nxt.active = 1'b0;
         st_nxt.sck = 1'b1;
         st_nxt.bitcnt = 3'h0;
         st_nxt.word = 3'h0;
      end

      // Pin driven only with an internal clock; idles high
      st_nxt.sck_oe = (st_nxt.clksel != CLK_EXT);
   end

   // State register
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         st_r <= '0;
         st_r.ph <= ST_IDLE;
         st_r.mode <= RST_MODE;
         st_r.clksel <= RST_CLKSEL;
         st_r.wait_sel <= RST_WAIT;
         st_r.count <= RST_COUNT;
         st_r.sck <= 1'b1;
         st_r.sck_oe <= 1'b1;
         st_r.sc1 <= 1'b1;
         st_r.sc2 <= 1'b1;
         st_r.sc3 <= 1'b1;
         st_r.rdy <= 1'b1;
      end else begin
         st_r <= st_nxt;
      end
   end

   // Outputs straight from the state register; hresp tied low
   assign hrdata = st_r.rdata;
   assign hreadyout = st_r.rdy;
   assign hresp = 1'b0;
   assign sck_o = st_r.sck;
   assign sck_oe = st_r.sck_oe;
   assign so = st_r.so;
   assign batch_interrupt = st_r.irq;

   abort_clears_a: assert property (@(posedge clk) disable iff (!reset_n)
      st_r.wr_pend && st_r.wr_idx == IDX_CTRL_MAIN
      && hwdata[CM_ABORT_BIT] |=> !st_r.active && st_r.ph == ST_IDLE)
      else $error("abort did not stop the transfer");

   active_flag_a: assert property (@(posedge clk) disable iff (!reset_n)
      (st_r.ph == ST_IDLE) == !st_r.active)
      else $error("active flag disagrees with engine");

   hold_clock_a: assert property (@(posedge clk) disable iff (!reset_n)
      st_r.ph == ST_HOLD && st_r.clksel != CLK_EXT |-> sck_o && sck_oe)
      else $error("clock pin not high during wait");

   hold_stays_a: assert property (@(posedge clk) disable iff (!reset_n)
      st_r.ph == ST_HOLD && !st_r.serviced && !svc_c && st_r.go
      && !(st_r.wr_pend && st_r.wr_idx == IDX_CTRL_MAIN
      && hwdata[CM_ABORT_BIT])
      |=> st_r.ph == ST_HOLD)
      else $error("wait left without service");

   lsb_out_a: assert property (@(posedge clk) disable iff (!reset_n)
      $fell(sck_o) && sck_oe |-> so == $past(st_r.shreg[0]))
      else $error("wrong bit on falling edge");

   batch_int_a: assert property (@(posedge clk) disable iff (!reset_n)
      batch_interrupt |-> st_r.word == 3'h0
      && $past(st_r.word) == $past(st_r.count))
      else $error("interrupt not at batch end");

   start_high_a: assert property (@(posedge clk) disable iff (!reset_n)
      $rose(st_r.active) |-> sck_o && st_r.word == 3'h0)
      else $error("start without clock high");

   nib_store_a: assert property (@(posedge clk) disable iff (!reset_n)
      done_c && nib_c && scb_mode_rx(st_r.mode)
      |=> st_r.buff[$past(st_r.word)][7:4] == 4'h0)
      else $error("upper nibble not cleared");

   rise_shift_a: assert property (@(posedge clk) disable iff (!reset_n)
      rise_c && !nib_c && !launch_c |=> st_r.shreg[7] == $past(st_r.si2))
      else $error("receive bit not sampled");

   go_end_a: assert property (@(posedge clk) disable iff (!reset_n)
      done_c && !st_r.go |=> !st_r.active)
      else $error("transfer did not end after word");

endmodule // scb_serial_port

// ### tb/scb_far_end.sv
`timescale 1ns/1ns
// Far peripheral: takes so on pin rises, puts si on pin falls
module scb_far_end (
   // Clock
   input wire logic clk,
   // Serial pins
   input wire logic sck_pin,
   input wire logic so,
   output logic si
);
   logic prev_r = 1'b1;
   int since_rise = 0;
   logic tx_q[$];
   logic rx_q[$];
   initial si = 1'b0;
   // Pin edges seen on the system clock; pulses span many cycles
   always @(posedge clk) begin
      prev_r <= sck_pin;
      since_rise <= since_rise + 1;
      if (prev_r && !sck_pin && tx_q.size() > 0) begin
         si <= tx_q.pop_front();
      end
      if (!prev_r && sck_pin) begin
         rx_q.push_back(so);
         since_rise <= 0;
      end
      // Hold time over: show the inverse so a late sample is caught
      if (since_rise == 4) begin
         si <= ~si;
      end
   end
endmodule // scb_far_end

// ### tb/test_clocked_serial_word_buffer.sv
`timescale 1ns/1ns
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin \
   n_fail++; $display("Error %0t: got %h want %h", $time, (a), (b)); end end
module test_clocked_serial_word_buffer;
   import scb_pkg::*;
   logic clk = 1'b0;
   logic reset_n = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] hrdata;
   logic hreadyout, hresp, sck_o, sck_oe, so, si, batch_interrupt;
   logic ext_sck = 1'b1;
   logic lf_clk = 1'b0;
   logic sck_pin;
   logic [7:0] q;
   int n_fail = 0;
   int samples_checked = 0;
   int n, h;
   int exps[6] = '{DIV_EXP_SEL0, DIV_EXP_SEL1, DIV_EXP_SEL2,
      DIV_EXP_SEL3, DIV_EXP_SEL4, DIV_EXP_SEL5};
   // Pin level: block output when enabled, else far clock (idles high)
   assign sck_pin = sck_oe ? sck_o : ext_sck;
   always #5 clk = ~clk;
   // Low-frequency source at a quarter of the system rate, off clk rises
   always #20 lf_clk = ~lf_clk;
   scb_serial_port DUT (.clk(clk), .reset_n(reset_n), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
      .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .sck_i(sck_pin), .sck_o(sck_o),
      .sck_oe(sck_oe), .so(so), .si(si), .lf_clk(lf_clk),
      .batch_interrupt(batch_interrupt));
   scb_far_end partner (.clk(clk), .sck_pin(sck_pin), .so(so), .si(si));

   task automatic report_and_stop;
      $display("Compares %0d, mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   // Bounded wait for hready at a rising edge
   task automatic wait_rdy;
      int k;
      k = 0;
      @(posedge clk);
      while (hreadyout !== 1'b1) begin
         k++;
         if (k > 40) begin
            n_fail++;
            report_and_stop();
         end
         @(posedge clk);
      end
   endtask
   // One single word transfer: address phase, then data phase
   task automatic ahb(input logic wr, input logic [11:0] idx,
      input logic [7:0] d);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= wr;
      haddr <= {18'h0, idx, 2'h0};
      wait_rdy();
      htrans <= 2'h0;
      hwdata <= {24'h0, d};
      wait_rdy();
      q = hrdata[7:0];
      `CHK(hresp, 1'b0)
      if (!wr) `CHK(hrdata[31:8], 24'h0)
   endtask
   task automatic wr(input logic [11:0] idx, input logic [7:0] d);
      ahb(1'b1, idx, d);
   endtask
   task automatic rd(input logic [11:0] idx);
      ahb(1'b0, idx, 8'h00);
   endtask
   // Clears go, then polls: the flag only drops once the engine has ended
   task automatic stop(input logic [2:0] m, input logic [2:0] c);
      int k;
      k = 0;
      wr(IDX_CTRL_MAIN, {2'b00, m, c});
      rd(IDX_STATUS);
      while (q[7] !== 1'b0 && k < 8) begin
         k++;
         rd(IDX_STATUS);
      end
      `CHK(q[7], 1'b0)
   endtask
   // Counts falling edges until the batch pulse, which stands one cycle
   task automatic wait_irq(input int lim, output int cyc);
      cyc = 0;
      do begin
         @(negedge clk);
         cyc++;
      end while (batch_interrupt !== 1'b1 && cyc < lim);
      if (batch_interrupt !== 1'b1) begin
         n_fail++;
         report_and_stop();
      end
      @(posedge clk);
   endtask
   task automatic push_word(input logic [7:0] d, input int nb);
      for (int i = 0; i < nb; i++) partner.tx_q.push_back(d[i]);
   endtask
   task automatic pop_word(input int nb, output logic [7:0] w);
      w = 8'h00;
      for (int i = 0; i < nb; i++) w[i] = partner.rx_q.pop_front();
   endtask
   // Far clock, 8 cycles low and high; returns right after the last rise
   task automatic ext_pulses(input int nb);
      for (int i = 0; i < nb; i++) begin
         ext_sck <= 1'b0;
         repeat (8) @(posedge clk);
         ext_sck <= 1'b1;
         if (i < nb - 1) repeat (8) @(posedge clk);
      end
   endtask

   // Main sequence
   initial begin
      repeat (4) @(posedge clk);
      reset_n <= 1'b1;
      rd(IDX_STATUS);
      `CHK(q, 8'h00)
      wr(IDX_WAIT_COUNT, 8'h1F);
      rd(IDX_WAIT_COUNT);
      `CHK(q, 8'h00)
      rd(12'h800);
      `CHK(q, 8'h00)
      // Reserved mode and reserved clock start nothing
      wr(IDX_CTRL_MAIN, {2'b10, 3'h1, 3'h5});
      rd(IDX_STATUS);
      `CHK(q[7], 1'b0)
      wr(IDX_CTRL_MAIN, {2'b10, MODE_TX8, CLK_RSV});
      rd(IDX_STATUS);
      `CHK(q[7], 1'b0)
      // Divider rates 1 to 5: one byte, then the wait holds until stopped
      wr(IDX_WAIT_COUNT, 8'h00);
      for (int s = 1; s <= 5; s++) begin
         h = 1 << (exps[s] - 1);
         partner.rx_q.delete();
         wr(IDX_BUF_BASE, 8'hA5 ^ 8'(s));
         wr(IDX_CTRL_MAIN, {2'b10, MODE_TX8, 3'(s)});
         #1;
         `CHK({sck_oe, sck_pin}, 2'b11)
         wait_irq(20000, n);
         `CHK(n >= 16 * h - 2 && n <= 16 * h + 6, 1'b1)
         repeat (40) @(posedge clk);
         rd(IDX_STATUS);
         `CHK({q[7], sck_pin}, 2'b11)
         stop(MODE_TX8, 3'(s));
         pop_word(8, q);
         `CHK(q, 8'hA5 ^ 8'(s))
      end
      // Low-frequency source: 16 ticks a half period, 4 cycles a tick
      wr(IDX_CONFIG, 8'h01);
      rd(IDX_CONFIG);
      `CHK(q, 8'h01)
      partner.rx_q.delete();
      wr(IDX_BUF_BASE, 8'h3A);
      wr(IDX_CTRL_MAIN, {2'b10, MODE_TX8, 3'h0});
      wait_irq(1200, n);
      `CHK(n >= 1010 && n <= 1040, 1'b1)
      stop(MODE_TX8, 3'h0);
      pop_word(8, q);
      `CHK(q, 8'h3A)
      wr(IDX_CONFIG, 8'h00);
      // Three nibble words from the lowest entries upward
      wr(IDX_WAIT_COUNT, 8'h02);
      for (int i = 0; i < 3; i++) begin
         wr(IDX_BUF_BASE + 12'(i), 8'hE1 + 8'(i * 17));
      end
      partner.rx_q.delete();
      wr(IDX_CTRL_MAIN, {2'b10, MODE_TX4, 3'h5});
      wait_irq(2000, n);
      stop(MODE_TX4, 3'h5);
      `CHK(partner.rx_q.size(), 12)
      for (int i = 0; i < 3; i++) begin
         pop_word(4, q);
         `CHK(q, 8'(i + 1))
      end
      // Full duplex with one word time of idle clock between words
      wr(IDX_WAIT_COUNT, 8'h09);
      wr(IDX_BUF_BASE, 8'h11);
      wr(IDX_BUF_BASE + 12'h1, 8'h22);
      push_word(8'h44, 8);
      push_word(8'h88, 8);
      partner.rx_q.delete();
      wr(IDX_CTRL_MAIN, {2'b10, MODE_TXRX8, 3'h5});
      repeat (100) @(posedge clk);
      rd(IDX_STATUS);
      `CHK(q[7:6], 2'b11)
      wait_irq(2000, n);
      `CHK(n >= 265 && n <= 300, 1'b1)
      stop(MODE_TXRX8, 3'h5);
      pop_word(8, q);
      `CHK(q, 8'h11)
      pop_word(8, q);
      `CHK(q, 8'h22)
      rd(IDX_BUF_BASE);
      `CHK(q, 8'h44)
      rd(IDX_BUF_BASE + 12'h1);
      `CHK(q, 8'h88)
      // Receive batches: a read frees the wait, count kept or renewed
      wr(IDX_WAIT_COUNT, 8'h01);
      push_word(8'h3C, 8);
      push_word(8'hC3, 8);
      push_word(8'h81, 8);
      push_word(8'h18, 8);
      push_word(8'h66, 8);
      wr(IDX_CTRL_MAIN, {2'b10, MODE_RX8, 3'h5});
      wait_irq(2000, n);
      rd(IDX_BUF_BASE);
      `CHK(q, 8'h3C)
      rd(IDX_BUF_BASE + 12'h1);
      `CHK(q, 8'hC3)
      wait_irq(2000, n);
      `CHK(n >= 240 && n <= 262, 1'b1)
      wr(IDX_WAIT_COUNT, 8'h00);
      rd(IDX_BUF_BASE);
      `CHK(q, 8'h81)
      wait_irq(2000, n);
      `CHK(n >= 115 && n <= 134, 1'b1)
      stop(MODE_RX8, 3'h5);
      rd(IDX_BUF_BASE + 12'h1);
      `CHK(q, 8'h18)
      rd(IDX_BUF_BASE);
      `CHK(q, 8'h66)
      // Nibble receive over a full entry clears its upper half
      wr(IDX_BUF_BASE, 8'hFF);
      push_word(8'h5A, 4);
      wr(IDX_CTRL_MAIN, {2'b10, MODE_RX4, 3'h5});
      wait_irq(1000, n);
      stop(MODE_RX4, 3'h5);
      rd(IDX_BUF_BASE);
      `CHK(q, 8'h0A)
      // Abort at the slowest rate, twice, to see the bit does not stick
      for (int i = 0; i < 2; i++) begin
         wr(IDX_CTRL_MAIN, {2'b10, MODE_TX8, 3'h0});
         rd(IDX_STATUS);
         `CHK(q[7], 1'b1)
         wr(IDX_CTRL_MAIN, {2'b01, MODE_TX8, 3'h0});
         rd(IDX_STATUS);
         `CHK({q[7], sck_pin}, 2'b01)
      end
      // Far clock: the block lets go of the pin and shifts on its edges
      partner.rx_q.delete();
      wr(IDX_BUF_BASE, 8'h96);
      wr(IDX_CTRL_MAIN, {2'b10, MODE_TX8, CLK_EXT});
      #1;
      `CHK(sck_oe, 1'b0)
      ext_pulses(7);
      repeat (8) @(posedge clk);
      // Go cleared before the last rise: the word completes, then it ends
      wr(IDX_CTRL_MAIN, {2'b00, MODE_TX8, CLK_EXT});
      ext_pulses(1);
      wait_irq(50, n);
      stop(MODE_TX8, CLK_EXT);
      pop_word(8, q);
      `CHK(q, 8'h96)
      report_and_stop();
   end
endmodule // test_clocked_serial_word_buffer
